//--- logic/tss_edge_detect.sv
// rising and falling edge detector for the sixteen trigger inputs
// assumes trigger inputs are already synchronous to i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module tss_edge_detect (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  tss_edge_if.detector e
);
  import tss_pkg::*;
  tss_edge_state_t s;
  tss_edge_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.prev = e.trig_level;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // compare against the previous sample of the same clock
  assign e.rise = e.trig_level & ~s.prev;
  assign e.fall = ~e.trig_level & s.prev;

  a_edge_rise_match: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $past(i_reset_n) |-> e.rise == (e.trig_level & ~$past(e.trig_level)))
    else $error("rise strobe does not match sampled transition");
  a_edge_fall_match: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $past(i_reset_n) |-> e.fall == (~e.trig_level & $past(e.trig_level)))
    else $error("fall strobe does not match sampled transition");
endmodule : tss_edge_detect
`default_nettype wire

//--- logic/tss_sequencer.sv
// trigger step sequencer: runs 8-bit step commands from a 32-entry queue
// assumes a single-cycle register port (read data one cycle after the strobe)
// and trigger inputs synchronous to i_ref_clk
//
// Overview of operation
// - opcode 0000 runs the control operation picked by the option nibble.
// - opcode 0001 adds the adjust value into the option-selected target register.
// - the copy form moves the hold value into the option-selected target register.
// - opcode 001x loads bit0 and option into the ADC positive input select.
// - opcode 0100 stalls until a rising edge on the selected trigger input.
// - opcode 0101 stalls until a falling edge on the selected trigger input.
// - opcode 0110 and reserved options execute as a step with no effect.
// - opcode 0111 raises the interrupt request picked by the option nibble.
// - opcode 100x pulses the trigger output picked by bit0 and option.
// - opcode 101x loads bit0 and option into the queue pointer.
// - opcode 110x with counter 0 at its limit just advances the pointer.
// - otherwise counter 0 increments and execution jumps to bit0 and option.
// - opcode 111x does the same using counter 1 and its limit.
// - the counter 1 limit serves both the counted jump and general counter 1.
// - the hold register keeps software data for the copy step.
// - hold and counter 1 limit ignore software writes while enabled and started.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"
module tss_sequencer (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire tss_pkg::tss_trig_in_t i_trig_in,
  output tss_pkg::tss_trig_out_t o_trig_out,
  output logic [4:0] o_adc_pos_sel,
  output logic o_irq
);
  import tss_pkg::*;

  tss_state_t s;
  tss_state_t next_s;
  tss_step_t step;
  logic running;
  logic stepping;
  logic [4:0] step_target;
  tss_edge_if edge_bus ();

  assign edge_bus.trig_level = i_trig_in;

  tss_edge_detect u_edge (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .e(edge_bus.detector)
  );

  assign running = s.enable & s.start;
  assign stepping = ((s.state == st_exec) || (s.state == st_wait)) && running;
  assign step = s.queue[s.qptr];
  assign step_target = {step.cmd[0], step.opt};

  function automatic logic [31:0] read_reg(input logic [7:0] a, input tss_state_t r);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[`TSS_QUEUE_BIT]) begin
      v = {24'h00_0000, r.queue[a[6:2]]};
    end else begin
      case (a)
        `TSS_OFF_CTRL: begin
          v[`TSS_CTRL_EN_BIT] = r.enable;
          v[`TSS_CTRL_START_BIT] = r.start;
        end
        `TSS_OFF_STATUS: begin
          v[4:0] = r.qptr;
          v[`TSS_STAT_BUSY_BIT] = (r.state != st_idle);
          v[`TSS_STAT_WAIT_BIT] = (r.state == st_wait);
        end
        `TSS_OFF_INT_STATUS: v[15:0] = r.int_status;
        `TSS_OFF_INT_MASK: v[15:0] = r.int_mask;
        `TSS_OFF_ADJUST: v[15:0] = r.adjust;
        `TSS_OFF_HOLD: v[15:0] = r.hold;
        `TSS_OFF_C0_LIMIT: v[15:0] = r.c0_limit;
        `TSS_OFF_C1_LIMIT: v[15:0] = r.c1_limit;
        `TSS_OFF_C0: v[15:0] = r.c0;
        `TSS_OFF_C1: v[15:0] = r.c1;
        `TSS_OFF_T0_LIMIT: v[15:0] = r.t0_limit;
        `TSS_OFF_T1_LIMIT: v[15:0] = r.t1_limit;
        `TSS_OFF_SD_LIMIT: v[15:0] = r.sd_limit;
        `TSS_OFF_LITERAL: v[15:0] = r.literal;
        `TSS_OFF_ADC_SEL: v[4:0] = r.adc_sel;
        default: v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction : read_reg

  // current value of an add/copy target; 6 and 7 select nothing
  function automatic tss_word_t target_value(input logic [2:0] sel, input tss_state_t r);
    tss_word_t v;
    v = `TSS_RESET_WORD;
    case (sel)
      `TSS_TGT_T0_LIMIT: v = r.t0_limit;
      `TSS_TGT_T1_LIMIT: v = r.t1_limit;
      `TSS_TGT_SD_LIMIT: v = r.sd_limit;
      `TSS_TGT_C0_LIMIT: v = r.c0_limit;
      `TSS_TGT_C1_LIMIT: v = r.c1_limit;
      `TSS_TGT_LITERAL: v = r.literal;
      default: v = `TSS_RESET_WORD;
    endcase
    return v;
  endfunction : target_value

  always_comb begin
    tss_word_t clr;
    tss_word_t set;
    tss_word_t tval;
    logic adv;
    clr = '0;
    set = '0;
    tval = `TSS_RESET_WORD;
    adv = 1'b0;
    next_s = s;
    next_s.rdata = 32'h0000_0000;
    next_s.trig_out = '0;

    // software side
    if (i_wr) begin
      case (i_addr)
        `TSS_OFF_CTRL: begin
          next_s.enable = i_wdata[`TSS_CTRL_EN_BIT];
          next_s.start = i_wdata[`TSS_CTRL_START_BIT];
        end
        `TSS_OFF_INT_STATUS: clr = i_wdata[15:0];
        `TSS_OFF_INT_MASK: next_s.int_mask = i_wdata[15:0];
        `TSS_OFF_ADJUST: next_s.adjust = i_wdata[15:0];
        `TSS_OFF_HOLD: begin
          if (!running) begin
            next_s.hold = i_wdata[15:0];
          end
        end
        `TSS_OFF_C0_LIMIT: next_s.c0_limit = i_wdata[15:0];
        `TSS_OFF_C1_LIMIT: begin
          if (!running) begin
            next_s.c1_limit = i_wdata[15:0];
          end
        end
        // live counters are only writable while the queue is not running
        `TSS_OFF_C0: begin
          if (!running) begin
            next_s.c0 = i_wdata[15:0];
          end
        end
        `TSS_OFF_C1: begin
          if (!running) begin
            next_s.c1 = i_wdata[15:0];
          end
        end
        `TSS_OFF_T0_LIMIT: next_s.t0_limit = i_wdata[15:0];
        `TSS_OFF_T1_LIMIT: next_s.t1_limit = i_wdata[15:0];
        `TSS_OFF_SD_LIMIT: next_s.sd_limit = i_wdata[15:0];
        `TSS_OFF_LITERAL: next_s.literal = i_wdata[15:0];
        default: begin
          if (i_addr[`TSS_QUEUE_BIT]) begin
            next_s.queue[i_addr[6:2]] = i_wdata[7:0];
          end
        end
      endcase
    end
    if (i_rd) begin
      next_s.rdata = read_reg(i_addr, s);
    end

    // step engine; a step written by software this cycle runs from the next
    case (s.state)
      st_idle: begin
        if (running) begin
          next_s.state = st_exec;
          next_s.qptr = 5'h00;
        end
      end
      st_exec, st_wait: begin
        if (!running) begin
          next_s.state = st_idle;
        end else begin
          adv = 1'b1;
          next_s.state = st_exec;
          case (step.cmd)
            `TSS_CMD_CTRL: begin
              case (step.opt)
                `TSS_CTRL_OPT_STOP: next_s.start = 1'b0;
                `TSS_CTRL_OPT_CLR_CNT: begin
                  next_s.c0 = `TSS_RESET_WORD;
                  next_s.c1 = `TSS_RESET_WORD;
                end
                default: ;
              endcase
            end
            `TSS_CMD_ADD_COPY: begin
              if (step.opt[`TSS_OPT_COPY_BIT]) begin
                tval = s.hold;
              end else begin
                tval = tss_word_t'(target_value(step.opt[2:0], s) + s.adjust);
              end
              case (step.opt[2:0])
                `TSS_TGT_T0_LIMIT: next_s.t0_limit = tval;
                `TSS_TGT_T1_LIMIT: next_s.t1_limit = tval;
                `TSS_TGT_SD_LIMIT: next_s.sd_limit = tval;
                `TSS_TGT_C0_LIMIT: next_s.c0_limit = tval;
                `TSS_TGT_C1_LIMIT: next_s.c1_limit = tval;
                `TSS_TGT_LITERAL: next_s.literal = tval;
                default: ;
              endcase
            end
            `TSS_CMD_WAIT_RISE: begin
              if (!edge_bus.rise[step.opt]) begin
                adv = 1'b0;
                next_s.state = st_wait;
              end
            end
            `TSS_CMD_WAIT_FALL: begin
              if (!edge_bus.fall[step.opt]) begin
                adv = 1'b0;
                next_s.state = st_wait;
              end
            end
            `TSS_CMD_IRQ: set[step.opt] = 1'b1;
            default: begin
              case (step.cmd[3:1])
                `TSS_CMD3_STROBE: next_s.adc_sel = step_target;
                `TSS_CMD3_TRIG: next_s.trig_out[step_target] = 1'b1;
                `TSS_CMD3_JUMP: begin
                  adv = 1'b0;
                  next_s.qptr = step_target;
                end
                `TSS_CMD3_JUMP_C0: begin
                  if (s.c0 != s.c0_limit) begin
                    adv = 1'b0;
                    next_s.c0 = tss_word_t'(s.c0 + 16'h0001);
                    next_s.qptr = step_target;
                  end
                end
                `TSS_CMD3_JUMP_C1: begin
                  if (s.c1 != s.c1_limit) begin
                    adv = 1'b0;
                    next_s.c1 = tss_word_t'(s.c1 + 16'h0001);
                    next_s.qptr = step_target;
                  end
                end
                default: ;
              endcase
            end
          endcase
          if (adv) begin
            next_s.qptr = 5'(s.qptr + 5'h01);
          end
        end
      end
      default: next_s.state = st_idle;
    endcase

    // a step event in the clearing cycle survives the clear
    next_s.int_status = (s.int_status & ~clr) | set;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
      s.state <= st_idle;
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata = s.rdata;
  assign o_trig_out = s.trig_out;
  assign o_adc_pos_sel = s.adc_sel;
  assign o_irq = |(s.int_status & s.int_mask);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  a_ctrl_stop_idle: assert property (
    stepping && step.cmd == `TSS_CMD_CTRL && step.opt == `TSS_CTRL_OPT_STOP
    |=> !s.start ##1 s.state == st_idle)
    else $error("stop step did not halt the queue");
  a_add_c1_limit: assert property (
    stepping && step.cmd == `TSS_CMD_ADD_COPY && step.opt == 4'h4
    |=> s.c1_limit == 16'($past(s.c1_limit) + $past(s.adjust)))
    else $error("add step result wrong");
  a_copy_c0_limit: assert property (
    stepping && step.cmd == `TSS_CMD_ADD_COPY && step.opt == 4'hB
    |=> s.c0_limit == $past(s.hold))
    else $error("copy step did not move hold value");
  a_adc_sel_load: assert property (
    stepping && step.cmd[3:1] == `TSS_CMD3_STROBE
    |=> o_adc_pos_sel == $past(step_target))
    else $error("adc select not loaded");
  a_wait_rise_stall: assert property (
    stepping && step.cmd == `TSS_CMD_WAIT_RISE && !edge_bus.rise[step.opt]
    |=> $stable(s.qptr))
    else $error("rise wait advanced without an edge");
  a_wait_fall_go: assert property (
    stepping && step.cmd == `TSS_CMD_WAIT_FALL && edge_bus.fall[step.opt]
    |=> s.qptr == 5'($past(s.qptr) + 5'h01))
    else $error("fall wait did not advance on edge");
  a_reserved_nop: assert property (
    stepping && step.cmd == `TSS_CMD_RESERVED
    |=> s.qptr == 5'($past(s.qptr) + 5'h01) && $stable(o_adc_pos_sel) && o_trig_out == '0)
    else $error("reserved step had an effect");
  a_irq_flag_set: assert property (
    stepping && step.cmd == `TSS_CMD_IRQ
    |=> s.int_status[$past(step_target[3:0])])
    else $error("interrupt step did not set its flag");
  a_trig_one_pulse: assert property (
    stepping && step.cmd[3:1] == `TSS_CMD3_TRIG
    |=> o_trig_out[$past(step_target)] && $onehot(o_trig_out))
    else $error("trigger pulse missing or extra");
  a_jump_load_ptr: assert property (
    stepping && step.cmd[3:1] == `TSS_CMD3_JUMP
    |=> s.qptr == $past(step_target))
    else $error("jump did not load pointer");
  a_loop0_done: assert property (
    stepping && step.cmd[3:1] == `TSS_CMD3_JUMP_C0 && s.c0 == s.c0_limit
    |=> s.qptr == 5'($past(s.qptr) + 5'h01) && $stable(s.c0))
    else $error("finished loop 0 did not fall through");
  a_loop0_again: assert property (
    stepping && step.cmd[3:1] == `TSS_CMD3_JUMP_C0 && s.c0 != s.c0_limit
    |=> s.c0 == 16'($past(s.c0) + 16'h0001) && s.qptr == $past(step_target))
    else $error("loop 0 did not count and jump");
  a_loop1_again: assert property (
    stepping && step.cmd[3:1] == `TSS_CMD3_JUMP_C1 && s.c1 != s.c1_limit
    |=> s.c1 == 16'($past(s.c1) + 16'h0001) && s.qptr == $past(step_target))
    else $error("loop 1 did not count and jump");
  a_hold_write_lock: assert property (
    i_wr && i_addr == `TSS_OFF_HOLD && running |=> $stable(s.hold))
    else $error("hold written while running");
  a_c1_limit_lock: assert property (
    i_wr && i_addr == `TSS_OFF_C1_LIMIT && running
    && !(stepping && step.cmd == `TSS_CMD_ADD_COPY) |=> $stable(s.c1_limit))
    else $error("counter 1 limit written while running");

  c_loop0_taken: cover property (stepping && step.cmd[3:1] == `TSS_CMD3_JUMP_C0
    && s.c0 != s.c0_limit);
  c_wait_state: cover property (s.state == st_wait ##1 s.state == st_exec);
  c_irq_raised: cover property (!o_irq ##1 o_irq);
  c_trig_pulse: cover property (o_trig_out != '0);
endmodule : tss_sequencer
`default_nettype wire

//--- shared/tss_edge_if.sv
// carries trigger levels into the edge detector and edge strobes back out
// assumes both ends run on the sequencer clock
`timescale 1ns/1ps
`default_nettype none
interface tss_edge_if;
  tss_pkg::tss_trig_in_t trig_level;
  tss_pkg::tss_trig_in_t rise;
  tss_pkg::tss_trig_in_t fall;
  modport detector (input trig_level, output rise, output fall);
  modport user (output trig_level, input rise, input fall);
endinterface : tss_edge_if
`default_nettype wire

//--- shared/tss_pkg.sv
// types shared by the step sequencer and its trigger edge detector
// assumes nothing beyond a SystemVerilog compiler
package tss_pkg;
  typedef logic [15:0] tss_trig_in_t;
  typedef logic [31:0] tss_trig_out_t;
  typedef logic [15:0] tss_word_t;
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] opt;
  } tss_step_t;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_exec = 3'b010,
    st_wait = 3'b100
  } tss_fsm_t;
  typedef struct packed {
    tss_fsm_t state;
    logic enable;
    logic start;
    logic [4:0] qptr;
    tss_word_t c0;
    tss_word_t c1;
    tss_word_t c0_limit;
    tss_word_t c1_limit;
    tss_word_t adjust;
    tss_word_t hold;
    tss_word_t t0_limit;
    tss_word_t t1_limit;
    tss_word_t sd_limit;
    tss_word_t literal;
    logic [4:0] adc_sel;
    tss_trig_out_t trig_out;
    tss_word_t int_status;
    tss_word_t int_mask;
    logic [31:0] rdata;
    logic [31:0][7:0] queue;
  } tss_state_t;
  typedef struct packed {
    tss_trig_in_t prev;
  } tss_edge_state_t;
endpackage : tss_pkg

//--- shared/tss_regs.svh
// register offsets, field positions, reset values and step encodings of the step sequencer
// assumes byte addresses on an 8-bit register port, one 32-bit word per register
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH

`define TSS_OFF_CTRL 8'h00
`define TSS_OFF_STATUS 8'h04
`define TSS_OFF_INT_STATUS 8'h08
`define TSS_OFF_INT_MASK 8'h0C
`define TSS_OFF_ADJUST 8'h10
`define TSS_OFF_HOLD 8'h14
`define TSS_OFF_C0_LIMIT 8'h18
`define TSS_OFF_C1_LIMIT 8'h1C
`define TSS_OFF_C0 8'h20
`define TSS_OFF_C1 8'h24
`define TSS_OFF_T0_LIMIT 8'h28
`define TSS_OFF_T1_LIMIT 8'h2C
`define TSS_OFF_SD_LIMIT 8'h30
`define TSS_OFF_LITERAL 8'h34
`define TSS_OFF_ADC_SEL 8'h38
// step queue: 32 entries at 0x80 + 4*index, bit 7 of the address selects it
`define TSS_QUEUE_BIT 7

`define TSS_CTRL_EN_BIT 0
`define TSS_CTRL_START_BIT 1
`define TSS_STAT_BUSY_BIT 8
`define TSS_STAT_WAIT_BIT 9

`define TSS_RESET_WORD 16'h0000

`define TSS_CMD_CTRL 4'h0
`define TSS_CMD_ADD_COPY 4'h1
`define TSS_CMD_WAIT_RISE 4'h4
`define TSS_CMD_WAIT_FALL 4'h5
`define TSS_CMD_RESERVED 4'h6
`define TSS_CMD_IRQ 4'h7
`define TSS_CMD3_STROBE 3'h1
`define TSS_CMD3_TRIG 3'h4
`define TSS_CMD3_JUMP 3'h5
`define TSS_CMD3_JUMP_C0 3'h6
`define TSS_CMD3_JUMP_C1 3'h7

`define TSS_CTRL_OPT_STOP 4'h1
`define TSS_CTRL_OPT_CLR_CNT 4'h2
`define TSS_OPT_COPY_BIT 3
`define TSS_TGT_T0_LIMIT 3'h0
`define TSS_TGT_T1_LIMIT 3'h1
`define TSS_TGT_SD_LIMIT 3'h2
`define TSS_TGT_C0_LIMIT 3'h3
`define TSS_TGT_C1_LIMIT 3'h4
`define TSS_TGT_LITERAL 3'h5

`endif

//--- tb/trigger_step_sequencer_bench.sv
// self-checking bench: register port tasks, one queued program, checks at the ports
// assumes the register map of tss_regs.svh and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"
module trigger_step_sequencer_bench;
  import tss_pkg::*;
  logic i_ref_clk;
  logic i_reset_n;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  tss_trig_in_t trig_in;
  tss_trig_in_t level;
  tss_trig_out_t o_trig_out;
  logic [4:0] o_adc_pos_sel;
  logic o_irq;
  logic [31:0][7:0] pulse_cnt;
  logic long_pulse;
  logic [31:0] rv;
  logic [7:0] prog [15];
  int fail_count;
  int n_tests;

  tss_sequencer tss_sequencer_inst (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trig_in(trig_in),
    .o_trig_out(o_trig_out), .o_adc_pos_sel(o_adc_pos_sel), .o_irq(o_irq)
  );
  tss_far_model tss_far_model_inst (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_level(level), .i_trig_out(o_trig_out),
    .o_trig_in(trig_in), .o_pulse_cnt(pulse_cnt), .o_long_pulse(long_pulse)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : reg_rd

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    reg_rd(a, v);
    check(name, v, exp);
  endtask : rd_chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    fail_count++;
    finish_test();
  end

  initial begin
    i_reset_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    level = 16'h0002;
    fail_count = 0;
    n_tests = 0;
    prog = '{8'h85, 8'h3A, 8'h73, 8'h60, 8'h1B, 8'h90, 8'hC5, 8'h40,
             8'h51, 8'h14, 8'h82, 8'hEA, 8'hAE, 8'h81, 8'h01};
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    rd_chk("hold reset", `TSS_OFF_HOLD, 32'h0000_0000);
    rd_chk("c1 limit reset", `TSS_OFF_C1_LIMIT, 32'h0000_0000);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    reg_wr(8'h3C, 32'h0000_ABCD);
    rd_chk("unmapped after write", 8'h3C, 32'h0000_0000);
    reg_wr(`TSS_OFF_HOLD, 32'h0000_0002);
    reg_wr(`TSS_OFF_C1_LIMIT, 32'h0000_0001);
    reg_wr(`TSS_OFF_ADJUST, 32'h0000_0003);
    reg_wr(`TSS_OFF_INT_MASK, 32'h0000_0008);
    rd_chk("hold written", `TSS_OFF_HOLD, 32'h0000_0002);
    for (int i = 0; i < 15; i++) begin
      reg_wr(8'h80 + 8'(4 * i), {24'h00_0000, prog[i]});
    end
    rd_chk("irq idle", `TSS_OFF_INT_STATUS, 32'h0000_0000);
    reg_wr(`TSS_OFF_CTRL, 32'h0000_0003);
    repeat (20) @(posedge i_ref_clk);
    // program is parked on the rising wait at entry 7
    rd_chk("rise wait stall", `TSS_OFF_STATUS, 32'h0000_0307);
    reg_wr(`TSS_OFF_HOLD, 32'h0000_0055);
    reg_wr(`TSS_OFF_C1_LIMIT, 32'h0000_0077);
    rd_chk("hold locked", `TSS_OFF_HOLD, 32'h0000_0002);
    rd_chk("c1 limit locked", `TSS_OFF_C1_LIMIT, 32'h0000_0001);
    rd_chk("still stalled", `TSS_OFF_STATUS, 32'h0000_0307);
    @(posedge i_ref_clk);
    level <= 16'h0003;
    repeat (6) @(posedge i_ref_clk);
    rd_chk("fall wait stall", `TSS_OFF_STATUS, 32'h0000_0308);
    @(posedge i_ref_clk);
    level <= 16'h0001;
    rv = 32'h0000_0100;
    for (int n = 0; n < 50 && rv[`TSS_STAT_BUSY_BIT] !== 1'b0; n++) begin
      reg_rd(`TSS_OFF_STATUS, rv);
    end
    check("stopped", 32'(rv[`TSS_STAT_BUSY_BIT]), 32'h0000_0000);
    check("trig5 pulses", 32'(pulse_cnt[5]), 32'h0000_0001);
    check("trig16 pulses", 32'(pulse_cnt[16]), 32'h0000_0003);
    check("trig2 pulses", 32'(pulse_cnt[2]), 32'h0000_0005);
    check("skipped step", 32'(pulse_cnt[1]), 32'h0000_0000);
    check("pulse width", 32'(long_pulse), 32'h0000_0000);
    check("adc select", 32'(o_adc_pos_sel), 32'h0000_001A);
    rd_chk("adc select reg", `TSS_OFF_ADC_SEL, 32'h0000_001A);
    rd_chk("c0 limit copied", `TSS_OFF_C0_LIMIT, 32'h0000_0002);
    rd_chk("c0 count", `TSS_OFF_C0, 32'h0000_0002);
    rd_chk("c1 limit added", `TSS_OFF_C1_LIMIT, 32'h0000_0004);
    rd_chk("c1 count", `TSS_OFF_C1, 32'h0000_0004);
    rd_chk("irq status", `TSS_OFF_INT_STATUS, 32'h0000_0008);
    check("irq line", 32'(o_irq), 32'h0000_0001);
    reg_wr(`TSS_OFF_INT_MASK, 32'h0000_0000);
    @(posedge i_ref_clk);
    #1;
    check("irq masked", 32'(o_irq), 32'h0000_0000);
    reg_wr(`TSS_OFF_INT_MASK, 32'h0000_0008);
    reg_wr(`TSS_OFF_INT_STATUS, 32'h0000_0008);
    rd_chk("irq cleared", `TSS_OFF_INT_STATUS, 32'h0000_0000);
    check("irq line low", 32'(o_irq), 32'h0000_0000);
    reg_wr(`TSS_OFF_HOLD, 32'h0000_1234);
    rd_chk("hold unlocked", `TSS_OFF_HOLD, 32'h0000_1234);
    finish_test();
  end
endmodule : trigger_step_sequencer_bench
`default_nettype wire

//--- tb/tss_far_model.sv
// far-side model: the trigger sources and trigger consumers around the sequencer
// assumes one clock shared with the sequencer; sources change only after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tss_far_model (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire tss_pkg::tss_trig_in_t i_level,
  input wire tss_pkg::tss_trig_out_t i_trig_out,
  output tss_pkg::tss_trig_in_t o_trig_in,
  output logic [31:0][7:0] o_pulse_cnt,
  output logic o_long_pulse
);
  import tss_pkg::*;
  tss_trig_out_t prev_out;
  // sources are registered, as a peripheral's flag would be, so edges stay clock aligned
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_trig_in <= 16'h0000;
      prev_out <= 32'h0000_0000;
      o_pulse_cnt <= '0;
      o_long_pulse <= 1'b0;
    end else begin
      o_trig_in <= i_level;
      prev_out <= i_trig_out;
      // a consumer counts one event per cycle that a trigger line is high
      for (int i = 0; i < 32; i++) begin
        if (i_trig_out[i] === 1'b1) begin
          o_pulse_cnt[i] <= o_pulse_cnt[i] + 8'h01;
        end
      end
      if ((i_trig_out & prev_out) !== 32'h0000_0000) begin
        o_long_pulse <= 1'b1;
      end
    end
  end
endmodule : tss_far_model
`default_nettype wire
